//--- rtl/uefc_pkg.sv
package uefc_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFF_EFC = 8'h00;
	localparam logic [7:0] OFF_IER = 8'h04;
	localparam logic [7:0] OFF_ISR = 8'h08;
	localparam logic [7:0] OFF_FCR = 8'h0C;
	localparam logic [7:0] OFF_MCR = 8'h10;
	localparam logic [7:0] OFF_RES1 = 8'h14;
	localparam logic [7:0] OFF_RES2 = 8'h18;
	localparam logic [7:0] OFF_PAU1 = 8'h1C;
	localparam logic [7:0] OFF_PAU2 = 8'h20;
	localparam logic [7:0] OFF_TRIG = 8'h24;
	localparam logic [7:0] OFF_STAT = 8'h28;

	// enhanced feature control fields
	localparam int EFC_AUTO_CTS = 7;
	localparam int EFC_AUTO_RTS = 6;
	localparam int EFC_SPEC = 5;
	localparam int EFC_ENH = 4;
	localparam int EFC_TX_HI = 3;
	localparam int EFC_TX_LO = 2;
	localparam int EFC_RX_HI = 1;
	localparam int EFC_RX_LO = 0;

	// event bits, shared by status and enable registers
	localparam int EV_TRIG = 0;
	localparam int EV_PAUSE = 1;
	localparam int EV_RESUME = 2;
	localparam int EV_CTS = 3;
	localparam int EV_SPEC = 4;
	localparam int EV_RTS = 5;

	// fields that software can only write while the enhanced bit is set, then the event bit mask
	localparam logic [7:0] IER_PROT = 8'hF0;
	localparam logic [7:0] ISR_PROT = 8'h30;
	localparam logic [7:0] FCR_PROT = 8'h30;
	localparam logic [7:0] MCR_PROT = 8'hE0;
	localparam logic [7:0] EV_MASK = 8'h3F;

	localparam int FCR_FIFO_EN = 0;
	localparam int MCR_RTS = 1;

	// values after reset, and the receive level width
	localparam logic [7:0] EFC_RST = 8'h00;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam int LEVEL_W = 7;
	localparam logic [6:0] TRIG_RST = 7'h01;

	// flow selection codes
	localparam logic [1:0] SEL_NONE = 2'b00;
	localparam logic [1:0] SEL_FIRST = 2'b10;
	localparam logic [1:0] SEL_SECOND = 2'b01;
	localparam logic [1:0] SEL_BOTH = 2'b11;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} uefc_rx_t;

	typedef struct packed {
		logic allow;
		logic [1:0] sel;
		logic dual;
		logic [15:0] resume_seq;
		logic [15:0] pause_seq;
	} uefc_txflow_t;

endpackage

//--- rtl/uefc_char_match.sv
`timescale 1ns/1ps
module uefc_char_match (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire uefc_pkg::uefc_rx_t rx,
	input wire logic [1:0] rx_sel,
	input wire logic dual,
	input wire logic spec_en,
	input wire logic [7:0] res1,
	input wire logic [7:0] res2,
	input wire logic [7:0] pau1,
	input wire logic [7:0] pau2,
	output logic resume_hit,
	output logic pause_hit,
	output logic spec_hit
);
	logic [7:0] prev_reg;
	logic prev_valid_reg;
	logic resume_reg;
	logic pause_reg;
	logic spec_reg;
	logic [7:0] one_res;
	logic [7:0] one_pau;
	logic dual_res;
	logic dual_pau;
	logic single_res;
	logic single_pau;
	logic res_next;
	logic pau_next;

	////////////////////////////////////////////////////////////////
	// bit 0 of every character register meets the received lsb
	assign one_res = (rx_sel == uefc_pkg::SEL_FIRST) ? res1 : res2;
	assign one_pau = (rx_sel == uefc_pkg::SEL_FIRST) ? pau1 : pau2;
	assign single_res = !dual && (rx_sel == uefc_pkg::SEL_FIRST ||
		rx_sel == uefc_pkg::SEL_SECOND) && rx.data == one_res;
	assign single_pau = !dual && (rx_sel == uefc_pkg::SEL_FIRST ||
		rx_sel == uefc_pkg::SEL_SECOND) && rx.data == one_pau;
	// two characters in order form one sequence
	assign dual_res = dual && prev_valid_reg && prev_reg == res1 &&
		rx.data == res2;
	assign dual_pau = dual && prev_valid_reg && prev_reg == pau1 &&
		rx.data == pau2;
	assign res_next = rx.valid && (single_res || dual_res);
	assign pau_next = rx.valid && (single_pau || dual_pau);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= 8'h00;
			prev_valid_reg <= 1'b0;
			resume_reg <= 1'b0;
			pause_reg <= 1'b0;
			spec_reg <= 1'b0;
		end else if (ce) begin
			resume_reg <= res_next;
			pause_reg <= pau_next;
			spec_reg <= rx.valid && spec_en && rx.data == pau2;
			if (rx.valid) begin
				prev_reg <= rx.data;
				// a finished pair must not seed an overlapping one
				prev_valid_reg <= !(dual_res || dual_pau);
			end
		end
	end

	assign resume_hit = resume_reg;
	assign pause_hit = pause_reg;
	assign spec_hit = spec_reg;
endmodule

//--- rtl/uefc_top.sv
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - auto CTS: high CTS pauses transmit
// - auto RTS: interrupt at trigger, RTS high after
// - RTS low again at or below trigger minus one
// - without hardware flow, RTS follows software bit
// - auto RTS read-back follows flow status
// - special detect compares second pause character
// - character bit 0 meets received lsb
// - protected fields writable only when enhanced set
// - clearing enhanced bit freezes protected fields
// - selection bits reset to zero
// - bits 3-2 pick transmit flow characters
// - bits 1-0 pick receive compare characters
// - receive 11 with transmit set compares pairs
// - dual mode sends or matches two in order
module uefc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire uefc_pkg::uefc_rx_t rx_in,
	input wire logic [uefc_pkg::LEVEL_W-1:0] rx_level,
	input wire logic cts_n,
	output logic rts_n,
	output uefc_pkg::uefc_txflow_t tx_flow,
	output logic irq
);
	localparam int LW = uefc_pkg::LEVEL_W;

	logic [7:0] efc_reg;
	logic [7:0] ier_reg;
	logic [7:0] isr_reg;
	logic [7:0] fcr_reg;
	logic [7:0] mcr_reg;
	logic [7:0] res1_reg;
	logic [7:0] res2_reg;
	logic [7:0] pau1_reg;
	logic [7:0] pau2_reg;
	logic [LW-1:0] trig_reg;
	logic [31:0] prdata_reg;
	logic cts_meta_reg;
	logic cts_sync_reg;
	logic cts_prev_reg;
	logic rts_hold_reg;
	logic rts_n_reg;
	logic trig_seen_reg;
	logic sw_paused_reg;
	logic tx_allow_reg;

	////////////////////////////////////////////////////////////////
	// protected fields keep their old value unless enhanced is set
	function automatic logic [7:0] guard(input logic [7:0] old_v,
		input logic [7:0] new_v, input logic [7:0] prot, input logic en);
		guard = en ? new_v : ((new_v & ~prot) | (old_v & prot));
	endfunction

	////////////////////////////////////////////////////////////////
	// bus decode
	wire setup = psel && !penable;
	wire access = psel && penable && ce;
	wire wr = access && pwrite;
	wire [7:0] wd = pwdata[7:0];
	wire hit_efc = paddr == uefc_pkg::OFF_EFC;
	wire hit_ier = paddr == uefc_pkg::OFF_IER;
	wire hit_isr = paddr == uefc_pkg::OFF_ISR;
	wire hit_fcr = paddr == uefc_pkg::OFF_FCR;
	wire hit_mcr = paddr == uefc_pkg::OFF_MCR;
	wire hit_res1 = paddr == uefc_pkg::OFF_RES1;
	wire hit_res2 = paddr == uefc_pkg::OFF_RES2;
	wire hit_pau1 = paddr == uefc_pkg::OFF_PAU1;
	wire hit_pau2 = paddr == uefc_pkg::OFF_PAU2;
	wire hit_trig = paddr == uefc_pkg::OFF_TRIG;
	wire hit_stat = paddr == uefc_pkg::OFF_STAT;
	wire mapped = hit_efc || hit_ier || hit_isr || hit_fcr || hit_mcr ||
		hit_res1 || hit_res2 || hit_pau1 || hit_pau2 || hit_trig ||
		hit_stat;
	wire enh = efc_reg[uefc_pkg::EFC_ENH];

	////////////////////////////////////////////////////////////////
	// mode decode
	wire [1:0] tx_sel = efc_reg[uefc_pkg::EFC_TX_HI:uefc_pkg::EFC_TX_LO];
	wire [1:0] rx_sel = efc_reg[uefc_pkg::EFC_RX_HI:uefc_pkg::EFC_RX_LO];
	wire fifo_en = fcr_reg[uefc_pkg::FCR_FIFO_EN];
	wire auto_cts = efc_reg[uefc_pkg::EFC_AUTO_CTS];
	// hardware rts flow needs the fifo to be running
	wire hw_rts = efc_reg[uefc_pkg::EFC_AUTO_RTS] && fifo_en;
	// receive 11 only means pairs when a transmit mode is also chosen
	wire rx_dual = rx_sel == uefc_pkg::SEL_BOTH &&
		tx_sel != uefc_pkg::SEL_NONE;
	wire rx_flow_on = rx_sel != uefc_pkg::SEL_NONE &&
		(rx_sel != uefc_pkg::SEL_BOTH || rx_dual);
	wire [LW-1:0] trig_m1 = trig_reg - LW'(1);
	wire at_trig = fifo_en && rx_level >= trig_reg;
	wire above_trig = fifo_en && rx_level > trig_reg;
	wire below_low = rx_level < trig_m1 || rx_level == trig_m1;

	////////////////////////////////////////////////////////////////
	// character matching
	logic resume_hit;
	logic pause_hit;
	logic spec_hit;

	uefc_char_match u_match (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.rx(rx_in),
		.rx_sel(rx_sel),
		.dual(rx_dual),
		.spec_en(efc_reg[uefc_pkg::EFC_SPEC]),
		.res1(res1_reg),
		.res2(res2_reg),
		.pau1(pau1_reg),
		.pau2(pau2_reg),
		.resume_hit(resume_hit),
		.pause_hit(pause_hit),
		.spec_hit(spec_hit)
	);

	////////////////////////////////////////////////////////////////
	// events into sticky status; set beats a same-cycle clear
	wire rts_edge = hw_rts && above_trig && !rts_hold_reg;
	wire [7:0] ev_set = {2'b00, rts_edge, spec_hit,
		cts_sync_reg != cts_prev_reg, resume_hit && rx_flow_on,
		pause_hit && rx_flow_on,
		hw_rts && at_trig && !trig_seen_reg};
	wire [7:0] isr_clr = (wr && hit_isr) ?
		(wd & uefc_pkg::EV_MASK & (enh ? 8'hFF : ~uefc_pkg::ISR_PROT)) :
		8'h00;
	wire [7:0] isr_next = (isr_reg & ~isr_clr) | ev_set;

	// readable auto-rts bit shows whether hardware flow is live
	wire [7:0] efc_rd = {efc_reg[7], hw_rts, efc_reg[5:0]};
	wire [7:0] stat_rd = {3'b000, sw_paused_reg, rts_hold_reg,
		tx_allow_reg, rts_n_reg, cts_sync_reg};
	wire [31:0] rd_mux =
		hit_efc ? {24'h000000, efc_rd} :
		hit_ier ? {24'h000000, ier_reg} :
		hit_isr ? {24'h000000, isr_reg} :
		hit_fcr ? {24'h000000, fcr_reg} :
		hit_mcr ? {24'h000000, mcr_reg} :
		hit_res1 ? {24'h000000, res1_reg} :
		hit_res2 ? {24'h000000, res2_reg} :
		hit_pau1 ? {24'h000000, pau1_reg} :
		hit_pau2 ? {24'h000000, pau2_reg} :
		hit_trig ? {{(32-LW){1'b0}}, trig_reg} :
		hit_stat ? {24'h000000, stat_rd} : 32'h00000000;

	////////////////////////////////////////////////////////////////
	// register file
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			efc_reg <= uefc_pkg::EFC_RST;
			ier_reg <= uefc_pkg::REG_RST;
			fcr_reg <= uefc_pkg::REG_RST;
			mcr_reg <= uefc_pkg::REG_RST;
			res1_reg <= uefc_pkg::REG_RST;
			res2_reg <= uefc_pkg::REG_RST;
			pau1_reg <= uefc_pkg::REG_RST;
			pau2_reg <= uefc_pkg::REG_RST;
			trig_reg <= uefc_pkg::TRIG_RST;
		end else if (wr) begin
			if (hit_efc)
				efc_reg <= wd;
			// legacy software cannot touch the protected fields
			if (hit_ier)
				ier_reg <= guard(ier_reg, wd, uefc_pkg::IER_PROT, enh);
			if (hit_fcr)
				fcr_reg <= guard(fcr_reg, wd, uefc_pkg::FCR_PROT, enh);
			if (hit_mcr)
				mcr_reg <= guard(mcr_reg, wd, uefc_pkg::MCR_PROT, enh);
			if (hit_res1)
				res1_reg <= wd;
			if (hit_res2)
				res2_reg <= wd;
			if (hit_pau1)
				pau1_reg <= wd;
			if (hit_pau2)
				pau2_reg <= wd;
			if (hit_trig)
				trig_reg <= pwdata[LW-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			isr_reg <= uefc_pkg::REG_RST;
			prdata_reg <= 32'h00000000;
		end else if (ce) begin
			isr_reg <= isr_next;
			if (setup)
				prdata_reg <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////
	// cts pin synchroniser; reset to the clear-to-send level so that
	// release of reset does not log a false cts change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cts_meta_reg <= 1'b0;
			cts_sync_reg <= 1'b0;
			cts_prev_reg <= 1'b0;
		end else if (ce) begin
			cts_meta_reg <= cts_n;
			cts_sync_reg <= cts_meta_reg;
			cts_prev_reg <= cts_sync_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// flow state
	wire hold_next = !hw_rts ? 1'b0 :
		above_trig ? 1'b1 :
		below_low ? 1'b0 : rts_hold_reg;
	wire rts_n_next = hw_rts ? hold_next :
		!mcr_reg[uefc_pkg::MCR_RTS];
	// pause/resume only act while receive flow is on
	wire paused_next = !rx_flow_on ? 1'b0 :
		pause_hit ? 1'b1 :
		resume_hit ? 1'b0 : sw_paused_reg;
	// the transmitter samples allow before each character start
	wire allow_next = !(auto_cts && cts_sync_reg) && !paused_next;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rts_hold_reg <= 1'b0;
			rts_n_reg <= 1'b1;
			trig_seen_reg <= 1'b0;
			sw_paused_reg <= 1'b0;
			tx_allow_reg <= 1'b1;
		end else if (ce) begin
			rts_hold_reg <= hold_next;
			rts_n_reg <= rts_n_next;
			trig_seen_reg <= hw_rts && at_trig;
			sw_paused_reg <= paused_next;
			tx_allow_reg <= allow_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs
	assign pready = penable && ce;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_reg;
	assign rts_n = rts_n_reg;
	assign irq = |(isr_reg & ier_reg & uefc_pkg::EV_MASK);
	assign tx_flow.allow = tx_allow_reg;
	assign tx_flow.sel = tx_sel;
	assign tx_flow.dual = tx_sel == uefc_pkg::SEL_BOTH;
	// dual mode sends first then second character
	assign tx_flow.resume_seq = (tx_sel == uefc_pkg::SEL_SECOND) ?
		{8'h00, res2_reg} : {res1_reg, res2_reg};
	assign tx_flow.pause_seq = (tx_sel == uefc_pkg::SEL_SECOND) ?
		{8'h00, pau2_reg} : {pau1_reg, pau2_reg};
endmodule

//--- bench/uefc_checker.sv
`timescale 1ns/1ps
module uefc_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [uefc_pkg::LEVEL_W-1:0] rx_level,
	input wire logic cts_n,
	input wire logic rts_n,
	input wire uefc_pkg::uefc_txflow_t tx_flow
);
	// shadow of the host view, rebuilt from bus writes
	logic [7:0] efc_reg;
	logic [6:0] trig_reg;
	logic fifo_reg;
	logic swr_reg;
	wire wr = psel & penable & ce & pwrite;
	wire auto_on = efc_reg[6] & fifo_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			efc_reg <= 8'h00;
			trig_reg <= 7'h01;
			fifo_reg <= 1'b0;
			swr_reg <= 1'b0;
		end else if (wr) begin
			if (paddr == uefc_pkg::OFF_EFC)
				efc_reg <= pwdata[7:0];
			if (paddr == uefc_pkg::OFF_TRIG)
				trig_reg <= pwdata[6:0];
			if (paddr == uefc_pkg::OFF_FCR)
				fifo_reg <= pwdata[0];
			if (paddr == uefc_pkg::OFF_MCR)
				swr_reg <= pwdata[1];
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////
	chk_ready_nowait: assert property (psel && penable && ce |-> pready)
		else $error("access phase without ready");
	chk_err_unmapped: assert property (
		psel && penable && paddr > uefc_pkg::OFF_STAT |-> pslverr)
		else $error("unmapped access without error");
	chk_cts_stop: assert property (
		(ce && efc_reg[7] && cts_n) [*3] |=> !tx_flow.allow)
		else $error("transmit not paused by cts");
	chk_cts_resume: assert property (
		(ce && (!cts_n || !efc_reg[7]) && efc_reg[1:0] == 2'b00) [*3]
		|=> tx_flow.allow)
		else $error("transmit not resumed");
	chk_rts_soft: assert property (
		(ce && !auto_on && $stable(swr_reg)) [*3] |-> rts_n == !swr_reg)
		else $error("rts does not follow software bit");
	chk_rts_raise: assert property (
		(ce && auto_on && rx_level > trig_reg) [*3] |-> rts_n)
		else $error("rts not raised above trigger");
	chk_rts_drop: assert property (
		(ce && auto_on && rx_level < trig_reg) [*3] |-> !rts_n)
		else $error("rts not dropped below trigger");
	chk_tx_select: assert property (
		tx_flow.sel == efc_reg[3:2]
		&& tx_flow.dual == (efc_reg[3:2] == 2'b11))
		else $error("transmit selection mismatch");
	chk_auto_readback: assert property (
		psel && penable && !pwrite && paddr == uefc_pkg::OFF_EFC
		|-> prdata == {24'h000000, efc_reg[7], auto_on, efc_reg[5:0]})
		else $error("control read-back wrong");
endmodule

bind uefc_top uefc_checker u_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rx_level(rx_level), .cts_n(cts_n), .rts_n(rts_n), .tx_flow(tx_flow));

//--- bench/uefc_remote.sv
`timescale 1ns/1ps
module uefc_remote (
	input wire logic pclk,
	output logic cts_n,
	output uefc_pkg::uefc_rx_t rx
);
	initial begin
		cts_n = 1'b0;
		rx = 9'h000;
	end
	// only commanded chars go out; flow chars are never used as data
	task automatic send(input logic [7:0] c);
		rx <= '{valid: 1'b1, data: c};
		@(posedge pclk);
		// stale data would hide a missing valid check
		rx <= '{valid: 1'b0, data: ~c};
		repeat (3) @(posedge pclk);
	endtask
	task automatic stop(input logic s);
		cts_n <= s;
	endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic cts_n, rts_n, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [uefc_pkg::LEVEL_W-1:0] rx_level;
	logic [1:0] s;
	uefc_pkg::uefc_rx_t rx;
	uefc_pkg::uefc_txflow_t tf;
	int num_errors = 0;
	int samples_checked = 0;

	uefc_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx),
		.rx_level(rx_level), .cts_n(cts_n), .rts_n(rts_n), .tx_flow(tf),
		.irq(irq));
	uefc_remote rem (.pclk(pclk), .cts_n(cts_n), .rx(rx));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] v, e);
		samples_checked++;
		if (v !== e) begin
			num_errors++;
			$display("ERROR %s expected %0h seen %0h", nm, e, v);
		end
	endtask
	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic xfer(input logic wt, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wt;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n == 20) begin
			num_errors++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// two edges so registered outputs have settled
		cyc(2);
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic r(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), rd, e);
	endtask
	task automatic lvl(input logic [6:0] l, input logic e);
		rx_level <= l;
		cyc(4);
		chk("rts_n", rts_n, e);
	endtask
	task automatic cts(input logic v, e);
		rem.stop(v);
		cyc(6);
		chk("allow", tf.allow, e);
	endtask
	task automatic flow(input logic [7:0] c, input logic [15:0] p, q,
		input logic two, e);
		w(uefc_pkg::OFF_EFC, {24'h0, c});
		if (two)
			rem.send(p[15:8]);
		rem.send(p[7:0]);
		chk("paused", tf.allow, !e);
		if (two)
			rem.send(q[15:8]);
		rem.send(q[7:0]);
		chk("resumed", tf.allow, 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		ce = 1'b1;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rx_level = 7'h00;
		cyc(10);
		presetn <= 1'b1;
		cyc(1);
		r(uefc_pkg::OFF_EFC, 32'h0);
		r(uefc_pkg::OFF_TRIG, 32'h1);
		w(uefc_pkg::OFF_IER, 32'hFF);
		r(uefc_pkg::OFF_IER, 32'h0F);
		w(uefc_pkg::OFF_EFC, 32'h10);
		w(uefc_pkg::OFF_IER, 32'hFF);
		w(uefc_pkg::OFF_MCR, 32'hE2);
		chk("rts_n", rts_n, 1'b0);
		w(uefc_pkg::OFF_EFC, 32'h00);
		w(uefc_pkg::OFF_IER, 32'h00);
		w(uefc_pkg::OFF_MCR, 32'h00);
		r(uefc_pkg::OFF_IER, 32'hF0);
		r(uefc_pkg::OFF_MCR, 32'hE0);
		chk("rts_n", rts_n, 1'b1);
		xfer(1'b0, 8'h2C, 32'h0);
		chk("unmapped", {err, rd[30:0]}, 32'h80000000);
		w(uefc_pkg::OFF_RES1, 32'h11);
		w(uefc_pkg::OFF_RES2, 32'h12);
		w(uefc_pkg::OFF_PAU1, 32'h13);
		w(uefc_pkg::OFF_PAU2, 32'h14);
		for (int i = 0; i < 4; i++) begin
			s = i[1:0];
			w(uefc_pkg::OFF_EFC, {28'h0, s, 2'b00});
			chk("sel", tf.sel, s);
			chk("dual", tf.dual, s == 2'b11);
			if (s[1])
				chk("pause", tf.pause_seq, 16'h1314);
			if (s[1])
				chk("resume2", tf.resume_seq, 16'h1112);
			if (s == 2'b01)
				chk("resume", tf.resume_seq, 16'h0012);
		end
		w(uefc_pkg::OFF_TRIG, 32'h04);
		w(uefc_pkg::OFF_FCR, 32'h01);
		w(uefc_pkg::OFF_EFC, 32'h50);
		w(uefc_pkg::OFF_IER, 32'h00);
		r(uefc_pkg::OFF_EFC, 32'h50);
		lvl(7'h00, 1'b0);
		lvl(7'h04, 1'b0);
		xfer(1'b0, uefc_pkg::OFF_ISR, 32'h0);
		chk("trig", rd[0], 1'b1);
		chk("irq", irq, 1'b0);
		w(uefc_pkg::OFF_IER, 32'h01);
		chk("irq", irq, 1'b1);
		lvl(7'h05, 1'b1);
		lvl(7'h04, 1'b1);
		lvl(7'h03, 1'b0);
		w(uefc_pkg::OFF_ISR, 32'h3F);
		chk("irq", irq, 1'b0);
		w(uefc_pkg::OFF_FCR, 32'h00);
		r(uefc_pkg::OFF_EFC, 32'h10);
		lvl(7'h09, 1'b1);
		w(uefc_pkg::OFF_MCR, 32'h02);
		lvl(7'h09, 1'b0);
		w(uefc_pkg::OFF_EFC, 32'h80);
		cts(1'b1, 1'b0);
		cts(1'b0, 1'b1);
		w(uefc_pkg::OFF_EFC, 32'h00);
		cts(1'b1, 1'b1);
		cts(1'b0, 1'b1);
		w(uefc_pkg::OFF_EFC, 32'h30);
		w(uefc_pkg::OFF_IER, 32'h10);
		w(uefc_pkg::OFF_ISR, 32'h3F);
		w(uefc_pkg::OFF_PAU2, 32'h01);
		rem.send(8'h80);
		chk("irq", irq, 1'b0);
		rem.send(8'h01);
		chk("irq", irq, 1'b1);
		xfer(1'b0, uefc_pkg::OFF_ISR, 32'h0);
		chk("special", rd[4], 1'b1);
		w(uefc_pkg::OFF_PAU2, 32'h14);
		flow(8'h02, 16'h0013, 16'h0011, 1'b0, 1'b1);
		flow(8'h01, 16'h0014, 16'h0012, 1'b0, 1'b1);
		flow(8'h0F, 16'h1314, 16'h1112, 1'b1, 1'b1);
		flow(8'h03, 16'h1314, 16'h1112, 1'b1, 1'b0);
		r(uefc_pkg::OFF_STAT, 32'h04);
		cyc(5);
		final_report();
	end
endmodule
